// >>> rtl/mio_pkg.sv
package mio_pkg;

  // Configuration pair addresses, chosen by the base strap.
  localparam logic [9:0] CFG_IDX_LO = 10'h398;
  localparam logic [9:0] CFG_IDX_HI = 10'h26E;

  // Register indices.
  localparam logic [7:0] IDX_FUNC_EN   = 8'h00;
  localparam logic [7:0] IDX_FUNC_ADDR = 8'h01;
  localparam logic [7:0] IDX_PWR_TEST  = 8'h02;

  // Reset values; bit 7 of the power and test register is loaded from a strap.
  localparam logic [7:0] FUNC_EN_RST   = 8'h00;
  localparam logic [7:0] FUNC_ADDR_RST = 8'h00;
  localparam logic [7:0] PWR_TEST_RST  = 8'h00;

  // Function enable fields.
  localparam int FE_PAR = 0;
  localparam int FE_SER1 = 1;
  localparam int FE_SER2 = 2;
  localparam int FE_FDC = 3;
  localparam int FE_ENCODE = 4;
  localparam int FE_FDC_SEC = 5;
  localparam int FE_DISK = 6;
  localparam int FE_DISK_SEC = 7;

  // Power and test fields.
  localparam int PT_SOFT_PD = 0;
  localparam int PT_XTAL_PD = 1;
  localparam int PT_CS_MODE = 2;
  localparam int PT_PAR_IRQ7 = 3;
  localparam int PT_TEST1 = 4;
  localparam int PT_TEST2 = 5;
  localparam int PT_LOCK = 6;
  localparam int PT_PAR_EXT = 7;

  // Interrupt pin positions on the irq bus.
  localparam int IRQ3 = 0;
  localparam int IRQ4 = 1;
  localparam int IRQ5 = 2;
  localparam int IRQ7 = 3;

  // Peripheral address ranges.
  localparam logic [9:0] FDC_PRI = 10'h3F0;
  localparam logic [9:0] FDC_SEC = 10'h370;
  localparam logic [9:0] DOR_OFS = 10'h002;
  localparam logic [9:0] DISK_PRI_A = 10'h1F0;
  localparam logic [9:0] DISK_PRI_B = 10'h3F6;
  localparam logic [9:0] DISK_SEC_A = 10'h170;
  localparam logic [9:0] DISK_SEC_B = 10'h376;
  localparam logic [9:0] PAR_B0 = 10'h378;
  localparam logic [9:0] PAR_B1 = 10'h3BC;
  localparam logic [9:0] PAR_B2 = 10'h278;
  localparam logic [9:0] SER_B0 = 10'h3F8;
  localparam logic [9:0] SER_B1 = 10'h2F8;

  // Crystal settle time after a crystal stop.
  localparam real XTAL_SETTLE_MS = 8.0;
  localparam real CLK_MHZ = 125.0;
  localparam int XTAL_SETTLE_CYC = int'(XTAL_SETTLE_MS * CLK_MHZ * 1000.0);

  // One host I/O cycle as seen by the block, synchronous to the clock.
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
    logic       io16;
  } mio_host_t;

endpackage : mio_pkg

// >>> rtl/mio_config.sv
module mio_config #(
  parameter int          XTAL_WAIT = mio_pkg::XTAL_SETTLE_CYC,
  parameter logic [9:0]  CS_BASE   = 10'h300
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire mio_pkg::mio_host_t host_i,
  output logic [7:0]             rd_data_o,
  output logic                   rd_data_oe_o,
  input  wire logic              config_base_strap_i,
  input  wire logic              port_output_strap_i,
  input  wire logic              pin_option_sel_i,
  input  wire logic              epp_enable_i,
  input  wire logic [7:0]        dor_i,
  input  wire logic              ser1_irq_i,
  input  wire logic              ser2_irq_i,
  input  wire logic              par_irq_i,
  input  wire logic              port_control_bit4_i,
  input  wire logic              ser1_sout_i,
  input  wire logic              ser2_sout_i,
  input  wire logic              ser1_baud_i,
  input  wire logic              ser2_baud_i,
  input  wire logic              ser1_lcr7_i,
  input  wire logic              ser2_lcr7_i,
  input  wire logic              zws_req_i,
  input  wire logic              shared_pin_i,
  output logic                   shared_pin_o,
  output logic                   shared_pin_oe_o,
  output logic                   par_sel_o,
  output logic                   ser1_sel_o,
  output logic                   ser2_sel_o,
  output logic                   fdc_sel_o,
  output logic                   ser1_clk_en_o,
  output logic                   ser2_clk_en_o,
  output logic                   fdc_clk_en_o,
  output logic                   xtal_en_o,
  output logic                   par_extended_o,
  output logic [3:0]             irq_o,
  output logic [3:0]             irq_oe_o,
  output logic                   drive_pin_a_o,
  output logic                   drive_pin_b_o,
  output logic                   motor_pin_a_o,
  output logic                   motor_pin_b_o,
  output logic                   disk_chip_select_a_n_o,
  output logic                   disk_chip_select_b_n_o,
  output logic                   disk_low_byte_enable_n_o,
  output logic                   disk_high_byte_enable_n_o,
  output logic                   disk_data_bit7_oe_o,
  output logic                   serial_out_first_o,
  output logic                   serial_out_second_o
);
  import mio_pkg::*;

  logic [7:0]  function_enable_reg_q;
  logic [7:0]  function_address_reg_q;
  logic [7:0]  power_test_reg_q;
  logic [7:0]  index_q;
  logic        init_q;
  logic        base_sel_q;
  logic [31:0] settle_q;
  logic        xtal_stop_q;
  logic [9:0]  idx_addr;
  logic        idx_hit;
  logic        dat_hit;
  logic        cfg_wr;
  logic [7:0]  cur_data;
  logic [9:0]  par_base;
  logic [9:0]  par_len;
  logic [9:0]  ser1_base;
  logic [9:0]  ser2_base;
  logic [9:0]  fdc_base;
  logic        pin_pd_mode;
  logic        power_down;
  logic        xtal_stop;
  logic        acc;
  logic        disk_a_hit;
  logic        disk_b_hit;
  logic [3:0]  irq_lvl;
  logic [3:0]  irq_en;

  // True when addr lies in [base, base+len).
  function automatic logic in_range(input logic [9:0] a, input logic [9:0] b,
                                    input logic [9:0] len);
    in_range = (a >= b) && ({1'b0, a} < ({1'b0, b} + {1'b0, len}));
  endfunction : in_range

  // Base of a serial port from its two-bit code and the third/fourth field.
  function automatic logic [9:0] ser_base(input logic [1:0] code, input logic [1:0] alt);
    logic [9:0] c3;
    logic [9:0] c4;
    case (alt)
      2'h0: begin c3 = 10'h3E8; c4 = 10'h2E8; end
      2'h1: begin c3 = 10'h338; c4 = 10'h238; end
      2'h2: begin c3 = 10'h2E8; c4 = 10'h2E0; end
      default: begin c3 = 10'h220; c4 = 10'h228; end
    endcase
    case (code)
      2'h0: ser_base = SER_B0;
      2'h1: ser_base = SER_B1;
      2'h2: ser_base = c3;
      default: ser_base = c4;
    endcase
  endfunction : ser_base

  // Configuration pair decode; the pair moves with the strap caught after reset.
  assign idx_addr = base_sel_q ? CFG_IDX_HI : CFG_IDX_LO;
  assign idx_hit  = host_i.addr == idx_addr;
  assign dat_hit  = host_i.addr == (idx_addr + 10'h001);
  assign cfg_wr   = host_i.wr && dat_hit && !power_test_reg_q[PT_LOCK];
  assign acc      = host_i.rd || host_i.wr;

  // Address ranges: parallel and serial from the function address register, floppy from the function enable register.
  always_comb begin
    case (function_address_reg_q[1:0])
      2'h0: begin par_base = PAR_B0; par_len = 10'h008; end
      2'h1: begin par_base = PAR_B1; par_len = 10'h003; end
      2'h2: begin par_base = PAR_B2; par_len = 10'h008; end
      default: begin par_base = PAR_B0; par_len = 10'h000; end
    endcase
    ser1_base = ser_base(function_address_reg_q[3:2], function_address_reg_q[7:6]);
    ser2_base = ser_base(function_address_reg_q[5:4], function_address_reg_q[7:6]);
    fdc_base  = function_enable_reg_q[FE_FDC_SEC] ? FDC_SEC : FDC_PRI;
  end

  // Disk ranges: eight-byte command block and the two control bytes.
  assign disk_a_hit = in_range(host_i.addr,
                               function_enable_reg_q[FE_DISK_SEC] ? DISK_SEC_A : DISK_PRI_A,
                               10'h008);
  assign disk_b_hit = in_range(host_i.addr,
                               function_enable_reg_q[FE_DISK_SEC] ? DISK_SEC_B : DISK_PRI_B,
                               10'h002);

  // Shared pin acts as a power-down input only with the option bits set that way.
  assign pin_pd_mode = pin_option_sel_i && !power_test_reg_q[PT_CS_MODE];
  assign power_down  = power_test_reg_q[PT_SOFT_PD] || (pin_pd_mode && !shared_pin_i);
  assign xtal_stop   = power_down && power_test_reg_q[PT_XTAL_PD];

  // Current value at the data port; unknown indices read as zero.
  always_comb begin
    case (index_q)
      IDX_FUNC_EN:   cur_data = function_enable_reg_q;
      IDX_FUNC_ADDR: cur_data = function_address_reg_q;
      IDX_PWR_TEST:  cur_data = power_test_reg_q;
      default:       cur_data = 8'h00;
    endcase
  end

  // Straps are caught on the first edge after reset, never under the reset itself.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_q     <= 1'b0;
      base_sel_q <= 1'b0;
    end else if (!init_q) begin
      init_q     <= 1'b1;
      base_sel_q <= config_base_strap_i;
    end
  end

  // Index register; not a configuration register, so the lock leaves it alone.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_q <= 8'h00;
    end else if (host_i.wr && idx_hit) begin
      index_q <= host_i.wdata;
    end
  end

  // Configuration registers; a write lands on the next edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      function_enable_reg_q  <= FUNC_EN_RST;
      function_address_reg_q <= FUNC_ADDR_RST;
      power_test_reg_q       <= PWR_TEST_RST;
    end else if (!init_q) begin
      power_test_reg_q[PT_PAR_EXT] <= !port_output_strap_i;
    end else if (cfg_wr) begin
      case (index_q)
        IDX_FUNC_EN:   function_enable_reg_q  <= host_i.wdata;
        IDX_FUNC_ADDR: function_address_reg_q <= host_i.wdata;
        IDX_PWR_TEST:  power_test_reg_q       <= host_i.wdata;
        default:       ;
      endcase
    end
  end

  // Read path returns what the registers hold now.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o    <= 8'h00;
      rd_data_oe_o <= 1'b0;
    end else begin
      rd_data_oe_o <= host_i.rd && (idx_hit || dat_hit);
      rd_data_o    <= idx_hit ? index_q : cur_data;
    end
  end

  // Crystal settle counter; clocks stay off until the crystal has had its time.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_stop_q <= 1'b0;
      settle_q    <= 32'h0000_0000;
    end else begin
      xtal_stop_q <= xtal_stop;
      if (xtal_stop) begin
        settle_q <= 32'(XTAL_WAIT);
      end else if (settle_q != 32'h0000_0000) begin
        settle_q <= settle_q - 32'h0000_0001;
      end
    end
  end

  // Clock enables; a disabled function keeps its state, only its clock stops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser1_clk_en_o  <= 1'b0;
      ser2_clk_en_o  <= 1'b0;
      fdc_clk_en_o   <= 1'b0;
      xtal_en_o      <= 1'b1;
      par_extended_o <= 1'b0;
    end else begin
      ser1_clk_en_o  <= function_enable_reg_q[FE_SER1] && !power_down
                        && settle_q == 32'h0000_0000;
      ser2_clk_en_o  <= function_enable_reg_q[FE_SER2] && !power_down
                        && settle_q == 32'h0000_0000;
      fdc_clk_en_o   <= function_enable_reg_q[FE_FDC] && !power_down
                        && settle_q == 32'h0000_0000;
      xtal_en_o      <= !xtal_stop;
      par_extended_o <= power_test_reg_q[PT_PAR_EXT] && !epp_enable_i;
    end
  end

  // Peripheral selects, each gated by its enable bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      par_sel_o  <= 1'b0;
      ser1_sel_o <= 1'b0;
      ser2_sel_o <= 1'b0;
      fdc_sel_o  <= 1'b0;
    end else begin
      par_sel_o  <= acc && function_enable_reg_q[FE_PAR]
                    && in_range(host_i.addr, par_base, par_len);
      ser1_sel_o <= acc && function_enable_reg_q[FE_SER1]
                    && in_range(host_i.addr, ser1_base, 10'h008);
      ser2_sel_o <= acc && function_enable_reg_q[FE_SER2]
                    && in_range(host_i.addr, ser2_base, 10'h008);
      fdc_sel_o  <= acc && function_enable_reg_q[FE_FDC]
                    && in_range(host_i.addr, fdc_base, 10'h008);
    end
  end

  // Disk interface controls, held inactive while the interface is off.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disk_chip_select_a_n_o    <= 1'b1;
      disk_chip_select_b_n_o    <= 1'b1;
      disk_low_byte_enable_n_o  <= 1'b1;
      disk_high_byte_enable_n_o <= 1'b1;
      disk_data_bit7_oe_o       <= 1'b0;
    end else begin
      disk_chip_select_a_n_o    <= !(acc && function_enable_reg_q[FE_DISK] && disk_a_hit);
      disk_chip_select_b_n_o    <= !(acc && function_enable_reg_q[FE_DISK] && disk_b_hit);
      disk_low_byte_enable_n_o  <= !(acc && function_enable_reg_q[FE_DISK]
                                     && (disk_a_hit || disk_b_hit));
      disk_high_byte_enable_n_o <= !(acc && function_enable_reg_q[FE_DISK]
                                     && disk_a_hit && host_i.io16);
      disk_data_bit7_oe_o       <= host_i.rd && function_enable_reg_q[FE_DISK]
                                   && disk_a_hit;
    end
  end

  // Drive and motor pins, direct active-low or encoded for an outside decoder.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_pin_a_o <= 1'b1;
      drive_pin_b_o <= 1'b1;
      motor_pin_a_o <= 1'b1;
      motor_pin_b_o <= 1'b1;
    end else if (function_enable_reg_q[FE_ENCODE]) begin
      drive_pin_a_o <= dor_i[0];
      drive_pin_b_o <= dor_i[1];
      motor_pin_a_o <= !dor_i[3'd4 + {1'b0, dor_i[1:0]}];
      motor_pin_b_o <= !(host_i.wr && host_i.addr == fdc_base + DOR_OFS);
    end else begin
      drive_pin_a_o <= dor_i[1:0] != 2'h0;
      drive_pin_b_o <= dor_i[1:0] != 2'h1;
      motor_pin_a_o <= !dor_i[4];
      motor_pin_b_o <= !dor_i[5];
    end
  end

  // Interrupt routing. Serial requests route regardless of the enable bit,
  // which is why software must mask them at the port before disabling it.
  always_comb begin
    irq_lvl = 4'h0;
    irq_en  = 4'h0;
    for (int i = 0; i < 2; i++) begin
      automatic logic [1:0] code = i == 0 ? function_address_reg_q[3:2]
                                          : function_address_reg_q[5:4];
      automatic logic       req  = i == 0 ? ser1_irq_i : ser2_irq_i;
      irq_en[code[0] ? IRQ3 : IRQ4]  = 1'b1;
      irq_lvl[code[0] ? IRQ3 : IRQ4] = irq_lvl[code[0] ? IRQ3 : IRQ4] | req;
    end
    if (function_enable_reg_q[FE_PAR]) begin
      case (function_address_reg_q[1:0])
        2'h0: begin
          irq_en[power_test_reg_q[PT_PAR_IRQ7] ? IRQ7 : IRQ5] = 1'b1;
          irq_lvl[power_test_reg_q[PT_PAR_IRQ7] ? IRQ7 : IRQ5] = par_irq_i && port_control_bit4_i;
        end
        2'h1: begin irq_en[IRQ7] = 1'b1; irq_lvl[IRQ7] = par_irq_i && port_control_bit4_i; end
        2'h2: begin irq_en[IRQ5] = 1'b1; irq_lvl[IRQ5] = par_irq_i && port_control_bit4_i; end
        default: ;
      endcase
    end
  end

  // Interrupt pins, serial test outputs and the shared option pin.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o               <= 4'h0;
      irq_oe_o            <= 4'h0;
      serial_out_first_o  <= 1'b1;
      serial_out_second_o <= 1'b1;
      shared_pin_o        <= 1'b1;
      shared_pin_oe_o     <= 1'b0;
    end else begin
      irq_o    <= irq_lvl;
      irq_oe_o <= irq_en;
      serial_out_first_o  <= (power_test_reg_q[PT_TEST1] && ser1_lcr7_i) ? ser1_baud_i
                                                                          : ser1_sout_i;
      serial_out_second_o <= (power_test_reg_q[PT_TEST2] && ser2_lcr7_i) ? ser2_baud_i
                                                                          : ser2_sout_i;
      if (!pin_option_sel_i) begin
        shared_pin_o    <= 1'b0;
        shared_pin_oe_o <= zws_req_i;
      end else begin
        shared_pin_o    <= !(acc && in_range(host_i.addr, CS_BASE, 10'h008));
        shared_pin_oe_o <= power_test_reg_q[PT_CS_MODE];
      end
    end
  end

  lock_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    init_q && power_test_reg_q[PT_LOCK] && host_i.wr && dat_hit |=>
      $stable(function_enable_reg_q) && $stable(function_address_reg_q)
      && $stable(power_test_reg_q))
    else $error("config write taken while locked");
  par_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !function_enable_reg_q[FE_PAR] |=> !par_sel_o)
    else $error("parallel port decoded while disabled");
  ser_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !function_enable_reg_q[FE_SER1] |=> !ser1_sel_o && !ser1_clk_en_o)
    else $error("first serial port active while disabled");
  ser_irq_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ser1_irq_i && function_address_reg_q[3:2] == 2'h0 |=> irq_o[IRQ4] && irq_oe_o[IRQ4])
    else $error("serial interrupt not routed");
  fdc_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !function_enable_reg_q[FE_FDC] |=> !fdc_sel_o && !fdc_clk_en_o)
    else $error("floppy active while disabled");
  enc_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    function_enable_reg_q[FE_ENCODE] |=>
      {drive_pin_b_o, drive_pin_a_o} == $past(dor_i[1:0]))
    else $error("encoded drive number wrong");
  motor_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    function_enable_reg_q[FE_ENCODE] && host_i.wr && host_i.addr == fdc_base + DOR_OFS
      |=> !motor_pin_b_o)
    else $error("latch pulse missing");
  disk_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !function_enable_reg_q[FE_DISK] |=> disk_chip_select_a_n_o && disk_chip_select_b_n_o
      && disk_low_byte_enable_n_o && !disk_data_bit7_oe_o)
    else $error("disk controls active while disabled");
  par_irq7_a: assert property (@(posedge clk_i) disable iff (rst_i)
    function_enable_reg_q[FE_PAR] && function_address_reg_q[1:0] == 2'h0
      && power_test_reg_q[PT_PAR_IRQ7] |=> irq_oe_o[IRQ7])
    else $error("parallel interrupt not moved to seven");
  xtal_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(xtal_stop) |=> !ser1_clk_en_o [*2])
    else $error("clock resumed before crystal settled");

endmodule : mio_config

// >>> dv/mio_dor_model.sv
module mio_dor_model
  import mio_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire mio_pkg::mio_host_t host_i,
  input  wire logic               fdc_sel_i,
  output logic [7:0]              dor_o
);
  timeunit 1ns;
  timeprecision 1ns;
  mio_host_t host_q;

  // The floppy output register latches a write only when its controller is selected.
  // The select lags the access by one cycle, so the host cycle is delayed to match it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_q <= '0;
      dor_o  <= 8'h00;
    end else begin
      host_q <= host_i;
      if (fdc_sel_i && host_q.wr && host_q.addr[2:0] == 3'h2) begin
        dor_o <= host_q.wdata;
      end
    end
  end
endmodule : mio_dor_model

// >>> dv/multi_io_function_config_tb_top.sv
module multi_io_function_config_tb_top
  import mio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i, rst_i, cbs, pos, psel, s1_irq, p_irq, ctl4, baud, lcr7;
  mio_host_t  host;
  logic [7:0] dor, rdat;
  logic       rd_oe, sh_o, sh_oe, par_sel, s1_sel, fdc_sel, s1_ck, fdc_ck, xtal;
  logic [3:0] irq, irq_oe;
  logic       dra, drb, mta, mtb, csa_n, csb_n, d7oe, so1;
  logic [9:0] base;
  logic       epp, pin, zero_wait_pin, pext, s2_sel, s2_ck, lbe_n, hbe_n, so2;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cyc = 0;
  logic [9:0] sa [4] = '{10'h3F8, 10'h2F8, 10'h2E8, 10'h228};
  logic [9:0] pa [3] = '{10'h378, 10'h3BC, 10'h278};
  int         pq [3] = '{IRQ5, IRQ7, IRQ5};

  mio_config #(.XTAL_WAIT(16)) u_mio_config (
    .clk_i(clk_i), .rst_i(rst_i), .host_i(host), .rd_data_o(rdat), .rd_data_oe_o(rd_oe),
    .config_base_strap_i(cbs), .port_output_strap_i(pos), .pin_option_sel_i(psel),
    .epp_enable_i(epp), .dor_i(dor), .ser1_irq_i(s1_irq), .ser2_irq_i(1'b0),
    .par_irq_i(p_irq), .port_control_bit4_i(ctl4), .ser1_sout_i(1'b0), .ser2_sout_i(1'b0),
    .ser1_baud_i(baud), .ser2_baud_i(baud), .ser1_lcr7_i(lcr7), .ser2_lcr7_i(lcr7),
    .zws_req_i(zero_wait_pin), .shared_pin_i(pin), .shared_pin_o(sh_o), .shared_pin_oe_o(sh_oe),
    .par_sel_o(par_sel), .ser1_sel_o(s1_sel), .ser2_sel_o(s2_sel), .fdc_sel_o(fdc_sel),
    .ser1_clk_en_o(s1_ck), .ser2_clk_en_o(s2_ck), .fdc_clk_en_o(fdc_ck), .xtal_en_o(xtal),
    .par_extended_o(pext), .irq_o(irq), .irq_oe_o(irq_oe), .drive_pin_a_o(dra),
    .drive_pin_b_o(drb), .motor_pin_a_o(mta), .motor_pin_b_o(mtb),
    .disk_chip_select_a_n_o(csa_n), .disk_chip_select_b_n_o(csb_n),
    .disk_low_byte_enable_n_o(lbe_n), .disk_high_byte_enable_n_o(hbe_n),
    .disk_data_bit7_oe_o(d7oe), .serial_out_first_o(so1), .serial_out_second_o(so2)
  );
  mio_dor_model u_mio_dor_model (
    .clk_i(clk_i), .rst_i(rst_i), .host_i(host), .fdc_sel_i(fdc_sel), .dor_o(dor)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // A hung handshake would stall the run, so a cycle ceiling forces the verdict.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One host I/O cycle; outputs are settled when the task returns.
  task automatic acc(input logic [9:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    host.addr  <= a;
    host.wdata <= d;
    host.wr    <= w;
    host.rd    <= ~w;
    @(posedge clk_i);
    host.wr <= 1'b0;
    host.rd <= 1'b0;
    #1;
  endtask : acc

  // One more edge, so that outputs registered from the new register value have settled.
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    acc(base, i, 1'b1);
    acc(base + 10'h001, d, 1'b1);
    tick();
  endtask : cfg

  task automatic creg(input logic [7:0] i, input logic [7:0] e);
    acc(base, i, 1'b1);
    acc(base + 10'h001, 8'h00, 1'b0);
    chk("cfg_rd", e, rdat);
    chk("cfg_oe", 8'h01, {7'h00, rd_oe});
  endtask : creg

  // Reset with both straps at one level; the pair moves with the base strap.
  task automatic do_rst(input logic s);
    rst_i <= 1'b1;
    cbs   <= s;
    pos   <= s;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    base  <= s ? CFG_IDX_HI : CFG_IDX_LO;
    repeat (2) @(posedge clk_i);
  endtask : do_rst

  initial begin
    {rst_i, cbs, pos, psel, s1_irq, p_irq, ctl4, baud, lcr7, epp, pin, zero_wait_pin} = 12'h802;
    host = '0;
    do_rst(1'b0);
    creg(IDX_FUNC_EN, 8'h00);
    creg(IDX_PWR_TEST, 8'h80);
    chk("par_ext", 8'h01, {7'h00, pext});
    epp <= 1'b1;
    tick();
    chk("par_ext_epp", 8'h00, {7'h00, pext});
    epp <= 1'b0;
    cfg(IDX_FUNC_EN, 8'h06);
    for (int i = 0; i < 4; i++) begin
      cfg(IDX_FUNC_ADDR, {i[1:0], i[1:0], i[1:0], 2'b00});
      acc(sa[i] + 10'h007, 8'h00, 1'b0);
      chk("ser_sel", 8'h03, {6'h00, s1_sel, s2_sel});
    end
    cfg(IDX_FUNC_ADDR, 8'h00);
    s1_irq <= 1'b1;
    cfg(IDX_FUNC_EN, 8'h00);
    acc(10'h3F8, 8'h00, 1'b0);
    chk("ser_off", 8'h00, {4'h0, s1_sel, s1_ck, s2_sel, s2_ck});
    chk("ser1_irq", 8'h03, {6'h00, irq[IRQ4], irq_oe[IRQ4]});
    s1_irq <= 1'b0;
    {p_irq, ctl4} <= 2'b11;
    cfg(IDX_FUNC_EN, 8'h01);
    for (int i = 0; i < 3; i++) begin
      cfg(IDX_FUNC_ADDR, 8'(i));
      acc(pa[i] + 10'h002, 8'h00, 1'b0);
      chk("par_sel", 8'h01, {7'h00, par_sel});
      chk("par_irq", 8'h03, {6'h00, irq[pq[i]], irq_oe[pq[i]]});
    end
    cfg(IDX_PWR_TEST, 8'h88);
    cfg(IDX_FUNC_ADDR, 8'h00);
    chk("par_irq7", 8'h06, {5'h00, irq[IRQ7], irq_oe[IRQ7], irq_oe[IRQ5]});
    cfg(IDX_FUNC_ADDR, 8'h03);
    chk("par_float", 8'h00, {6'h00, irq_oe[IRQ7], irq_oe[IRQ5]});
    cfg(IDX_FUNC_EN, 8'h00);
    cfg(IDX_FUNC_ADDR, 8'h00);
    acc(10'h378, 8'h00, 1'b0);
    chk("par_off", 8'h00, {7'h00, par_sel});
    cfg(IDX_FUNC_EN, 8'h08);
    acc(10'h3F0, 8'h00, 1'b0);
    chk("fdc_pri", 8'h03, {6'h00, fdc_sel, fdc_ck});
    cfg(IDX_FUNC_EN, 8'h38);
    acc(10'h3F0, 8'h00, 1'b0);
    chk("fdc_gone", 8'h00, {7'h00, fdc_sel});
    acc(10'h372, 8'h12, 1'b1);
    chk("latch_pulse", 8'h00, {7'h00, mtb});
    repeat (3) @(posedge clk_i);
    #1;
    chk("encoded", 8'h0E, {4'h0, mtb, mta, drb, dra});
    cfg(IDX_FUNC_EN, 8'h28);
    chk("direct", 8'h0B, {4'h0, mtb, mta, drb, dra});
    cfg(IDX_FUNC_EN, 8'h00);
    acc(10'h1F0, 8'h00, 1'b0);
    chk("disk_off", 8'h03, {5'h00, d7oe, csa_n, lbe_n});
    cfg(IDX_FUNC_EN, 8'h40);
    host.io16 <= 1'b1;
    acc(10'h1F7, 8'h00, 1'b0);
    chk("disk_pri", 8'h08, {4'h0, d7oe, csa_n, lbe_n, hbe_n});
    host.io16 <= 1'b0;
    cfg(IDX_FUNC_EN, 8'hC0);
    acc(10'h376, 8'h00, 1'b0);
    chk("disk_sec", 8'h00, {6'h00, csb_n, lbe_n});
    cfg(IDX_FUNC_EN, 8'h02);
    cfg(IDX_PWR_TEST, 8'h81);
    chk("soft_pd", 8'h01, {6'h00, s1_ck, xtal});
    cfg(IDX_PWR_TEST, 8'h83);
    chk("xtal_pd", 8'h00, {6'h00, s1_ck, xtal});
    cfg(IDX_PWR_TEST, 8'h82);
    chk("settling", 8'h01, {6'h00, s1_ck, xtal});
    repeat (20) @(posedge clk_i);
    #1;
    chk("settled", 8'h01, {7'h00, s1_ck});
    {baud, lcr7} <= 2'b11;
    cfg(IDX_PWR_TEST, 8'h90);
    chk("test_mode", 8'h01, {6'h00, so2, so1});
    zero_wait_pin <= 1'b1;
    tick();
    chk("zws_out", 8'h02, {6'h00, sh_oe, sh_o});
    zero_wait_pin  <= 1'b0;
    psel <= 1'b1;
    pin  <= 1'b0;
    tick();
    chk("pin_pd", 8'h00, {6'h00, s1_ck, sh_oe});
    pin <= 1'b1;
    tick();
    chk("pin_wake", 8'h01, {7'h00, s1_ck});
    cfg(IDX_PWR_TEST, 8'h84);
    acc(10'h300, 8'h00, 1'b0);
    chk("cs_out", 8'h02, {6'h00, sh_oe, sh_o});
    cfg(IDX_PWR_TEST, 8'hC0);
    cfg(IDX_FUNC_EN, 8'hFF);
    creg(IDX_FUNC_EN, 8'h02);
    do_rst(1'b1);
    creg(IDX_PWR_TEST, 8'h00);
    chk("par_ext_rst", 8'h00, {7'h00, pext});
    test_done();
  end
endmodule : multi_io_function_config_tb_top
